// ==== design/civu_map.vh ====
// constants for the interrupt vectoring unit
`ifndef CIVU_MAP_VH
`define CIVU_MAP_VH
`define CIVU_REG_CTRL 32'h0000_0000
`define CIVU_REG_ENABLE 32'h0000_0004
`define CIVU_REG_FLAGS 32'h0000_0008
`define CIVU_REG_LEVEL_TYPE 32'h0000_000c
`define CIVU_REG_STATUS 32'h0000_0010
`define CIVU_REG_BOOT_START 32'h0000_0014
`define CIVU_REG_SP 32'h0000_0018
`define CIVU_REG_PC 32'h0000_001c
`define CIVU_CTRL_VECTOR_TABLE_SELECT_BIT 0
`define CIVU_CTRL_GIE_BIT 1
`define CIVU_CTRL_GIE_SET_BIT 2
`define CIVU_CTRL_GIE_CLR_BIT 3
`define CIVU_CTRL_RESET 32'h0000_0000
`define CIVU_BOOT_START_RESET 16'h0f00
`define CIVU_SP_RESET 16'h04ff
`define CIVU_ENTRY_CYC 4'h4
`define CIVU_WAKE_CYC 4'h4
`define CIVU_JUMP_CYC 4'h3
`define CIVU_RETURN_CYC 4'h4
`define CIVU_SP_STEP 16'h0002
`endif

// ==== design/civu_arbiter.v ====
// fixed-priority pick of the lowest pending and enabled source
`timescale 1ns/1ps
module civu_arbiter #(
  parameter N = 8,
  parameter IW = 5
) (
  input wire [N-1:0] req,
  output reg any,
  output reg [IW-1:0] idx
);
  integer i;
  always @*
  begin
    any = 1'b0;
    idx = {IW{1'b0}};
    // R1: lowest index wins
    for (i = N - 1; i >= 0; i = i - 1)
    begin
      if (req[i])
      begin
        any = 1'b1;
        idx = i[IW-1:0];
      end
    end
  end
endmodule // civu_arbiter

// ==== design/civu_flags.v ====
// pending flags: set by events, cleared by vectoring or write-one
`timescale 1ns/1ps
module civu_flags #(
  parameter N = 8
) (
  input wire clk,
  input wire rst_n,
  input wire [N-1:0] event_in,
  input wire [N-1:0] hw_clear,
  input wire [N-1:0] sw_clear,
  output reg [N-1:0] flags
);
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1)
    begin : g_flag
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          flags[g] <= 1'b0;
        // R12: set wins, held until cleared
        else if (event_in[g])
          flags[g] <= 1'b1;
        // R10: R11: hw vector or w1c clear
        else if (hw_clear[g] || sw_clear[g])
          flags[g] <= 1'b0;
      end
    end
  endgenerate
endmodule // civu_flags

// ==== design/civu_top.v ====
// interrupt vectoring unit with ahb-lite register slave and core handshake
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "civu_map.vh"
// Summary of operation
// R1: each source has its own low vector; lower vector address wins.
// R2: reset ranks first, then external request zero, then all others.
// R3: a source is served only when its enable and global enable are set.
// R4: boot lock bits may suppress interrupts depending on program counter.
// R5: vector table select moves interrupt vectors to boot section start.
// R6: reset vector fuse moves reset vector to boot section start.
// R7: accepting an interrupt clears global enable.
// R8: software may set global enable in a handler, allowing nesting.
// R9: return from interrupt sets global enable.
// R10: vectoring to a flag source clears its flag in hardware.
// R11: writing one to a flag clears it; zero leaves it.
// R12: events while disabled set the flag and hold it.
// R13: pending flags wait for global enable, then serve in priority order.
// R14: level sources request only while their condition is present.
// R15: after return, one main instruction runs before next interrupt.
// R16: status register is neither saved nor restored by hardware.
// R17: disable instruction acts at once, even against a simultaneous request.
// R18: after enable instruction, next instruction runs before pending service.
// R19: entry takes four cycles pushing program counter; vector jump three more.
// R20: a multi-cycle instruction finishes before entry starts.
// R21: waking from sleep adds four cycles to entry.
// R22: return takes four cycles, pops program counter, sp up two, sets enable.
// R23: entry push lowers stack pointer by two.
// R24: one request with highest-priority vector index goes to the core.
module civu_top #(
  parameter N = 8,
  parameter IW = 5,
  parameter PCW = 16
) (
  input wire clk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [N-1:0] irq_event,
  input wire [N-1:0] irq_level,
  input wire instr_boundary,
  input wire instr_cli,
  input wire instr_sei,
  input wire return_from_irq_instr,
  input wire cpu_sleeping,
  input wire [PCW-1:0] program_counter,
  input wire reset_vector_fuse,
  input wire boot_lock_app_bit,
  input wire boot_lock_boot_bit,
  output reg irq_request,
  output reg [IW-1:0] irq_index,
  output reg core_hold,
  output reg pc_load,
  output reg [PCW-1:0] pc_load_value,
  output reg [PCW-1:0] stack_pointer,
  output reg push_strobe,
  output reg pop_strobe,
  output reg global_enable
);
  localparam S_RUN = 5'b00001;
  localparam S_WAKE = 5'b00010;
  localparam S_ENTRY = 5'b00100;
  localparam S_JUMP = 5'b01000;
  localparam S_RET = 5'b10000;
  localparam [3:0] ENTRY_CYC = `CIVU_ENTRY_CYC;
  localparam [3:0] WAKE_CYC = `CIVU_WAKE_CYC;
  localparam [3:0] JUMP_CYC = `CIVU_JUMP_CYC;
  localparam [3:0] RET_CYC = `CIVU_RETURN_CYC;

  reg [4:0] state;
  reg [3:0] cnt;
  reg [N-1:0] enable;
  reg [N-1:0] level_type;
  reg vector_table_select;
  reg [PCW-1:0] boot_start;
  reg [PCW-1:0] saved_pc;
  reg [IW-1:0] taken_idx;
  reg hold_one;
  reg reset_pending;
  reg ph_write;
  reg ph_valid;
  reg [7:0] ph_addr;
  reg [N-1:0] hw_clear;
  reg [N-1:0] sw_clear;
  wire [N-1:0] flags;
  wire [N-1:0] pend;
  wire [N-1:0] req;
  wire any;
  wire [IW-1:0] idx;
  wire lock_block;
  wire take;
  wire [PCW-1:0] vec_base;
  wire [PCW-1:0] rst_base;
  wire ph_take;

  civu_flags #(.N(N)) u_flags (
    .clk(clk),
    .rst_n(rst_n),
    .event_in(irq_event & ~level_type),
    .hw_clear(hw_clear),
    .sw_clear(sw_clear),
    .flags(flags)
  );

  // R14: level sources follow condition
  assign pend = (flags & ~level_type) | (irq_level & level_type);
  // R3: source enable gating; global enable gates take
  assign req = pend & enable;
  civu_arbiter #(.N(N), .IW(IW)) u_arb (
    .req(req),
    .any(any),
    .idx(idx)
  );

  // R4: suppress while inside locked section
  assign lock_block = (boot_lock_boot_bit && !vector_table_select &&
                       program_counter >= boot_start) ||
                      (boot_lock_app_bit && vector_table_select &&
                       program_counter < boot_start);
  // R17: cli blocks same-cycle take
  // R15: R18: hold_one forces one instruction
  // R20: wait for instruction boundary
  assign take = (state == S_RUN) && any && global_enable && !instr_cli &&
                !hold_one && !lock_block && (instr_boundary || cpu_sleeping) &&
                !reset_pending;
  // R5: vector table relocation
  assign vec_base = vector_table_select ? boot_start : {PCW{1'b0}};
  // R6: reset vector relocation
  assign rst_base = reset_vector_fuse ? boot_start : {PCW{1'b0}};
  assign ph_take = hsel && htrans[1] && hready;

  // ahb-lite slave: zero wait, always okay
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      ph_valid <= ph_take;
      ph_write <= hwrite;
      ph_addr <= haddr[7:0];
    end
  end

  always @*
  begin
    sw_clear = {N{1'b0}};
    // R11: write one clears flag
    if (ph_valid && ph_write && ph_addr == `CIVU_REG_FLAGS)
      sw_clear = hwdata[N-1:0];
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hrdata <= 32'h0000_0000;
    else if (ph_take && !hwrite)
    begin
      case (haddr[7:0])
        `CIVU_REG_CTRL: hrdata <= {30'h0, global_enable, vector_table_select};
        `CIVU_REG_ENABLE: hrdata <= {{(32-N){1'b0}}, enable};
        `CIVU_REG_FLAGS: hrdata <= {{(32-N){1'b0}}, flags};
        `CIVU_REG_LEVEL_TYPE: hrdata <= {{(32-N){1'b0}}, level_type};
        `CIVU_REG_STATUS: hrdata <= {{(31-IW){1'b0}}, any, idx};
        `CIVU_REG_BOOT_START: hrdata <= {{(32-PCW){1'b0}}, boot_start};
        `CIVU_REG_SP: hrdata <= {{(32-PCW){1'b0}}, stack_pointer};
        `CIVU_REG_PC: hrdata <= {{(32-PCW){1'b0}}, saved_pc};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // software-written configuration
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable <= {N{1'b0}};
      level_type <= {N{1'b0}};
      vector_table_select <= 1'b0;
      boot_start <= `CIVU_BOOT_START_RESET;
    end
    else if (ph_valid && ph_write)
    begin
      case (ph_addr)
        `CIVU_REG_CTRL: vector_table_select <= hwdata[`CIVU_CTRL_VECTOR_TABLE_SELECT_BIT];
        `CIVU_REG_ENABLE: enable <= hwdata[N-1:0];
        `CIVU_REG_LEVEL_TYPE: level_type <= hwdata[N-1:0];
        `CIVU_REG_BOOT_START: boot_start <= hwdata[PCW-1:0];
        default: enable <= enable;
      endcase
    end
  end

  // sequencer for entry, jump and return
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= S_RUN;
      cnt <= 4'h0;
      global_enable <= 1'b0;
      hold_one <= 1'b0;
      reset_pending <= 1'b1;
      saved_pc <= {PCW{1'b0}};
      taken_idx <= {IW{1'b0}};
      stack_pointer <= `CIVU_SP_RESET;
      hw_clear <= {N{1'b0}};
      core_hold <= 1'b0;
      pc_load <= 1'b0;
      pc_load_value <= {PCW{1'b0}};
      push_strobe <= 1'b0;
      pop_strobe <= 1'b0;
      irq_request <= 1'b0;
      irq_index <= {IW{1'b0}};
    end
    else
    begin
      hw_clear <= {N{1'b0}};
      pc_load <= 1'b0;
      push_strobe <= 1'b0;
      pop_strobe <= 1'b0;
      // R24: request and index each cycle
      irq_request <= any && global_enable;
      irq_index <= idx + {{(IW-1){1'b0}}, 1'b1};
      if (instr_boundary)
        hold_one <= 1'b0;
      // R2: R6: reset vector first after release
      if (reset_pending)
      begin
        reset_pending <= 1'b0;
        pc_load <= 1'b1;
        pc_load_value <= rst_base;
      end
      case (state)
        S_RUN:
        begin
          // R17: cli immediate
          if (instr_cli)
            global_enable <= 1'b0;
          // R18: sei delays service one instruction
          else if (instr_sei)
          begin
            global_enable <= 1'b1;
            hold_one <= 1'b1;
          end
          // R8: software enable via register
          else if (ph_valid && ph_write && ph_addr == `CIVU_REG_CTRL)
          begin
            if (hwdata[`CIVU_CTRL_GIE_SET_BIT])
              global_enable <= 1'b1;
            else if (hwdata[`CIVU_CTRL_GIE_CLR_BIT])
              global_enable <= 1'b0;
          end
          if (return_from_irq_instr && instr_boundary)
          begin
            state <= S_RET;
            cnt <= RET_CYC - 4'h1;
            core_hold <= 1'b1;
          end
          else if (take)
          begin
            // R7: clear global enable on accept
            global_enable <= 1'b0;
            taken_idx <= idx;
            saved_pc <= program_counter;
            core_hold <= 1'b1;
            // R10: clear served flag
            hw_clear <= ~level_type & ({{(N-1){1'b0}}, 1'b1} << idx);
            // R21: four extra cycles from sleep
            if (cpu_sleeping)
            begin
              state <= S_WAKE;
              cnt <= WAKE_CYC - 4'h1;
            end
            else
            begin
              state <= S_ENTRY;
              cnt <= ENTRY_CYC - 4'h1;
            end
          end
        end
        S_WAKE:
        begin
          if (cnt == 4'h0)
          begin
            state <= S_ENTRY;
            cnt <= ENTRY_CYC - 4'h1;
          end
          else
            cnt <= cnt - 4'h1;
        end
        S_ENTRY:
        begin
          // R19: four-cycle entry with push
          // R16: status register untouched
          if (cnt == 4'h0)
          begin
            // R23: push lowers sp by two
            stack_pointer <= stack_pointer - `CIVU_SP_STEP;
            push_strobe <= 1'b1;
            // R1: vector per source above reset
            pc_load <= 1'b1;
            pc_load_value <= vec_base + {{(PCW-IW-1){1'b0}},
                             taken_idx + {{(IW-1){1'b0}}, 1'b1}, 1'b0};
            state <= S_JUMP;
            cnt <= JUMP_CYC - 4'h1;
          end
          else
            cnt <= cnt - 4'h1;
        end
        S_JUMP:
        begin
          // R19: three-cycle vector jump
          if (cnt == 4'h0)
          begin
            state <= S_RUN;
            core_hold <= 1'b0;
          end
          else
            cnt <= cnt - 4'h1;
        end
        S_RET:
        begin
          // R22: four-cycle return
          if (cnt == 4'h0)
          begin
            stack_pointer <= stack_pointer + `CIVU_SP_STEP;
            pop_strobe <= 1'b1;
            pc_load <= 1'b1;
            pc_load_value <= saved_pc;
            // R9: return sets global enable
            global_enable <= 1'b1;
            // R15: one instruction before next
            hold_one <= 1'b1;
            // R13: remaining flags then served in order
            state <= S_RUN;
            core_hold <= 1'b0;
          end
          else
            cnt <= cnt - 4'h1;
        end
        default:
        begin
          state <= S_RUN;
          core_hold <= 1'b0;
        end
      endcase
    end
  end
endmodule // civu_top

// ==== verification/civu_sva.sv ====
// port assertions for the vectoring unit
`timescale 1ns/1ps
module civu_sva #(
  parameter PCW = 16
) (
  input wire clk,
  input wire rst_n,
  input wire hreadyout,
  input wire hresp,
  input wire irq_request,
  input wire core_hold,
  input wire pc_load,
  input wire [PCW-1:0] stack_pointer,
  input wire push_strobe,
  input wire pop_strobe,
  input wire global_enable,
  input wire instr_cli,
  input wire instr_sei
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay)
    else $error("bus wait or error");
  property p_push_sp;
    push_strobe |-> stack_pointer == $past(stack_pointer) - 16'h0002;
  endproperty
  a_push_sp: assert property (p_push_sp)
    else $error("push stack step");
  property p_entry;
    push_strobe |-> $past(core_hold, 3) && pc_load && !global_enable;
  endproperty
  a_entry: assert property (p_entry)
    else $error("entry too short");
  property p_jump;
    push_strobe |=> core_hold [*2] ##1 !core_hold;
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump length");
  property p_pop;
    pop_strobe |-> stack_pointer == $past(stack_pointer) + 16'h0002 && global_enable;
  endproperty
  a_pop: assert property (p_pop)
    else $error("return pop");
  property p_ret_len;
    pop_strobe |-> $past(core_hold, 3) ##1 !core_hold;
  endproperty
  a_ret_len: assert property (p_ret_len)
    else $error("return gap");
  property p_cli;
    instr_cli |=> !global_enable && !core_hold;
  endproperty
  a_cli: assert property (p_cli)
    else $error("taken after disable");
  property p_sei;
    instr_sei && !global_enable |=> !core_hold;
  endproperty
  a_sei: assert property (p_sei)
    else $error("taken right at enable");
  property p_gate;
    !global_enable ##1 !global_enable |-> !irq_request;
  endproperty
  a_gate: assert property (p_gate)
    else $error("request while disabled");
  c_push: cover property (push_strobe);
  c_pop: cover property (pop_strobe);
  c_cli: cover property (instr_cli);
endmodule // civu_sva

bind civu_top civu_sva #(.PCW(PCW)) civu_sva_inst (
  .clk(clk), .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp),
  .irq_request(irq_request), .core_hold(core_hold), .pc_load(pc_load),
  .stack_pointer(stack_pointer), .push_strobe(push_strobe), .pop_strobe(pop_strobe),
  .global_enable(global_enable), .instr_cli(instr_cli), .instr_sei(instr_sei));

// ==== verification/civu_core_model.sv ====
// behavioural core: boundaries, disable, enable and return pulses
`timescale 1ns/1ps
module civu_core_model (
  input wire clk,
  input wire rst_n,
  input wire slow,
  input wire core_hold,
  input wire pc_load,
  input wire [15:0] pc_load_value,
  output reg instr_boundary,
  output reg instr_cli,
  output reg instr_sei,
  output reg return_from_irq_instr,
  output reg cpu_sleeping,
  output reg [15:0] program_counter
);
  initial
  begin
    instr_cli = 1'b0;
    instr_sei = 1'b0;
    return_from_irq_instr = 1'b0;
    cpu_sleeping = 1'b0;
  end
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      instr_boundary <= 1'b0;
      program_counter <= 16'h0000;
    end
    else
    begin
      instr_boundary <= !core_hold && !(slow && instr_boundary);
      if (pc_load)
        program_counter <= pc_load_value;
      else if (instr_boundary)
        program_counter <= program_counter + 16'h0001;
    end
  end
  // sleep level, changed just after a rising edge
  task doze(input on);
  begin
    @(posedge clk);
    cpu_sleeping <= on;
  end
  endtask
  // one-cycle instruction pulse: 0 disable, 1 enable, 2 return
  task pulse(input [1:0] kind);
  begin
    @(posedge clk);
    instr_cli <= (kind == 2'd0);
    instr_sei <= (kind == 2'd1);
    return_from_irq_instr <= (kind == 2'd2);
    @(posedge clk);
    instr_cli <= 1'b0;
    instr_sei <= 1'b0;
    return_from_irq_instr <= 1'b0;
  end
  endtask
endmodule // civu_core_model

// ==== verification/civu_tb_top.sv ====
// self-checking bench for the vectoring unit
`timescale 1ns/1ps
`include "civu_map.vh"
module civu_tb_top;
  reg clk;
  reg rst_n;
  reg hsel;
  reg [31:0] haddr;
  reg [1:0] htrans;
  reg hwrite;
  reg [2:0] hsize;
  reg [31:0] hwdata;
  reg [7:0] irq_event;
  reg [7:0] irq_level;
  reg reset_vector_fuse;
  reg boot_lock_app_bit;
  reg boot_lock_boot_bit;
  reg slow;
  reg [31:0] rd;
  wire [31:0] hrdata;
  wire hreadyout, hresp, irq_request, core_hold, pc_load, push_strobe, pop_strobe;
  wire global_enable, instr_boundary, instr_cli, instr_sei, return_from_irq_instr;
  wire cpu_sleeping;
  wire [4:0] irq_index;
  wire [15:0] pc_load_value, stack_pointer, program_counter;
  integer mismatches;
  integer checked;
  civu_top #(.N(8), .IW(5), .PCW(16)) civu_top_inst (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_event(irq_event),
    .irq_level(irq_level), .instr_boundary(instr_boundary), .instr_cli(instr_cli),
    .instr_sei(instr_sei), .return_from_irq_instr(return_from_irq_instr),
    .cpu_sleeping(cpu_sleeping), .program_counter(program_counter),
    .reset_vector_fuse(reset_vector_fuse), .boot_lock_app_bit(boot_lock_app_bit),
    .boot_lock_boot_bit(boot_lock_boot_bit),
    .irq_request(irq_request), .irq_index(irq_index), .core_hold(core_hold),
    .pc_load(pc_load), .pc_load_value(pc_load_value), .stack_pointer(stack_pointer),
    .push_strobe(push_strobe), .pop_strobe(pop_strobe), .global_enable(global_enable));
  civu_core_model civu_core_model_inst (
    .clk(clk), .rst_n(rst_n), .slow(slow), .core_hold(core_hold), .pc_load(pc_load),
    .pc_load_value(pc_load_value), .instr_boundary(instr_boundary),
    .instr_cli(instr_cli), .instr_sei(instr_sei),
    .return_from_irq_instr(return_from_irq_instr), .cpu_sleeping(cpu_sleeping),
    .program_counter(program_counter));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task check(input [31:0] got, input [31:0] exp);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task end_of_test;
  begin
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task bus(input [31:0] a, input w, input [31:0] d);
  begin
    @(posedge clk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge clk);
    while (!hreadyout) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (!hreadyout) @(posedge clk);
    rd = hrdata;
  end
  endtask
  task fire(input [7:0] m);
  begin
    @(posedge clk);
    irq_event <= m;
    @(posedge clk);
    irq_event <= 8'h00;
  end
  endtask
  task wait_strobe(input pop);
    integer n;
  begin
    n = 0;
    @(negedge clk);
    while ((pop ? pop_strobe : push_strobe) !== 1'b1 && n < 60)
    begin
      @(negedge clk);
      n = n + 1;
    end
    check(n, n < 60 ? n : -1);
  end
  endtask
  task take(input [15:0] vec);
  begin
    wait_strobe(1'b0);
    check(pc_load_value, vec);
    check(stack_pointer, 16'h04fd);
    check(global_enable, 1'b0);
  end
  endtask
  task ret;
  begin
    repeat (4) @(negedge clk);
    civu_core_model_inst.pulse(2'd2);
    wait_strobe(1'b1);
    check(stack_pointer, 16'h04ff);
    check(global_enable, 1'b1);
  end
  endtask
  task t_regs;
  begin
    bus(`CIVU_REG_BOOT_START, 1'b0, 0);
    check(rd, 32'h0f00);
    bus(32'h0000_0040, 1'b0, 0);
    check(rd, 0);
    bus(`CIVU_REG_SP, 1'b1, 32'h1234);
    bus(`CIVU_REG_SP, 1'b0, 0);
    check(rd, 32'h04ff);
  end
  endtask
  task t_order;
  begin
    bus(`CIVU_REG_ENABLE, 1'b1, 32'h5);
    fire(8'h05);
    bus(`CIVU_REG_FLAGS, 1'b0, 0);
    check(rd, 32'h5);
    bus(`CIVU_REG_CTRL, 1'b1, 32'h4);
    take(16'h0002);
    bus(`CIVU_REG_FLAGS, 1'b0, 0);
    check(rd, 32'h4);
    ret;
    take(16'h0006);
    bus(`CIVU_REG_CTRL, 1'b1, 32'h1);
    fire(8'h04);
    ret;
    take(16'h0f06);
    ret;
  end
  endtask
  task t_flags;
  begin
    fire(8'h20);
    bus(`CIVU_REG_FLAGS, 1'b0, 0);
    check(rd, 32'h20);
    check(core_hold, 1'b0);
    bus(`CIVU_REG_FLAGS, 1'b1, 0);
    bus(`CIVU_REG_FLAGS, 1'b0, 0);
    check(rd, 32'h20);
    bus(`CIVU_REG_FLAGS, 1'b1, 32'h20);
    bus(`CIVU_REG_FLAGS, 1'b0, 0);
    check(rd, 0);
  end
  endtask
  task t_cli;
  begin
    // flag already pending at the disable edge, so only the disable stops the take
    fork
      fire(8'h01);
      begin
        @(posedge clk);
        civu_core_model_inst.pulse(2'd0);
      end
    join
    bus(`CIVU_REG_FLAGS, 1'b0, 0);
    check(rd, 32'h1);
    check(global_enable, 1'b0);
    @(posedge clk);
    slow <= 1'b1;
    civu_core_model_inst.pulse(2'd1);
    take(16'h0f02);
    @(posedge clk);
    slow <= 1'b0;
    ret;
  end
  endtask
  task t_sleep;
  begin
    civu_core_model_inst.doze(1'b1);
    fire(8'h01);
    repeat (9) @(negedge clk);
    check(push_strobe, 1'b0);
    @(negedge clk);
    check(push_strobe, 1'b1);
    check(pc_load_value, 16'h0f02);
    civu_core_model_inst.doze(1'b0);
    ret;
  end
  endtask
  task t_level;
  begin
    bus(`CIVU_REG_LEVEL_TYPE, 1'b1, 32'h2);
    @(posedge clk);
    irq_level <= 8'h02;
    bus(`CIVU_REG_STATUS, 1'b0, 0);
    check(rd, 32'h0);
    @(posedge clk);
    irq_level <= 8'h00;
    bus(`CIVU_REG_ENABLE, 1'b1, 32'h7);
    repeat (8) @(negedge clk);
    check(core_hold, 1'b0);
    @(posedge clk);
    irq_level <= 8'h02;
    take(16'h0f04);
    @(posedge clk);
    irq_level <= 8'h00;
    ret;
  end
  endtask
  task t_lock;
  begin
    @(posedge clk);
    boot_lock_app_bit <= 1'b1;
    fire(8'h01);
    repeat (8) @(negedge clk);
    check(core_hold, 1'b0);
    check(irq_request, 1'b1);
    check(irq_index, 32'h1);
    @(posedge clk);
    boot_lock_app_bit <= 1'b0;
    take(16'h0f02);
    ret;
  end
  endtask
  task t_reset;
  begin
    @(posedge clk);
    reset_vector_fuse <= 1'b1;
    boot_lock_boot_bit <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check(pc_load, 1'b1);
    check(pc_load_value, 16'h0f00);
    bus(`CIVU_REG_ENABLE, 1'b1, 32'h1);
    fire(8'h01);
    bus(`CIVU_REG_CTRL, 1'b1, 32'h4);
    repeat (8) @(negedge clk);
    check(core_hold, 1'b0);
    @(posedge clk);
    boot_lock_boot_bit <= 1'b0;
    take(16'h0002);
    ret;
  end
  endtask
  initial
  begin
    #(50 * 6000);
    mismatches = mismatches + 1;
    end_of_test;
  end
  initial
  begin
    mismatches = 0;
    checked = 0;
    rst_n = 1'b0;
    hsel = 1'b1;
    haddr = 0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 0;
    irq_event = 8'h00;
    irq_level = 8'h00;
    reset_vector_fuse = 1'b0;
    boot_lock_app_bit = 1'b0;
    boot_lock_boot_bit = 1'b0;
    slow = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check(pc_load, 1'b1);
    check(pc_load_value, 16'h0000);
    check(stack_pointer, 16'h04ff);
    t_regs;
    t_order;
    t_flags;
    t_cli;
    t_sleep;
    t_level;
    t_lock;
    t_reset;
    end_of_test;
  end
endmodule // civu_tb_top
